/* File: rtl/host_ctrl_port.sv */
// Function
// - answer one of three slave addresses picked by the address-select pin
// - acknowledge a matching address byte during the ninth clock
// - second write byte loads pointer, is acknowledged, next byte lands there
// - pointer advances after each written byte, except at register zero
// - auto-increment never wraps into the next page
// - start then read address resets pointer to register zero
// - pointer advances after each transmitted byte; stop accepted anytime except in the clock high of a start
// - write address, pointer, repeated start, read address reads chosen register
// - read data bits are valid at the rising clock edge
// - spi uses clock, mosi, miso and active-low select, below 20 MHz (half the 40 MHz core clock)
// - spi samples mosi on rise, drives miso on fall, ignores clock unselected
// - select high keeps miso released and spi logic in reset
// - select rising mid-transfer discards the partial word, no register change
// - miso stays released until the register address is decoded
// - any number of write words accepted within one select, each with its own header
// - active-low full shutdown stops all but the control interface
// - active-high audio path shutdown stops codec, processor keeps running
// - port-select low means i2c, high means spi, same register space
// - stop recognised anywhere except in the same clock high as start
`timescale 1ns/1ps
module host_ctrl_port
  import host_port_pkg::*;
(
  input  wire logic       core_clk_i,        // core clock, 40 MHz
  input  wire logic       nrst_i,            // sync reset, active low
  input  wire logic       clk_en_i,          // clock enable, freezes state when low
  input  wire logic       port_sel_i,        // pin: 0 i2c, 1 spi
  input  wire logic [1:0] addr_sel_i,        // pin: slave address select level
  input  wire logic       scl_sclk_i,        // pin: i2c scl or spi sclk
  input  wire logic       sda_mosi_i,        // pin: i2c sda in or spi mosi
  input  wire logic       cs_n_i,            // pin: spi chip select, active low
  output logic            sda_o,             // sda drive value, always low
  output logic            sda_oe_o,          // sda pull-down enable
  output logic            miso_o,            // spi miso value
  output logic            miso_oe_o,         // spi miso drive enable
  output logic [9:0]      reg_addr_o,        // register address
  output logic [7:0]      reg_wdata_o,       // register write data
  output logic            reg_we_o,          // register write pulse
  output logic            reg_re_o,          // register read pulse
  input  wire logic [7:0] reg_rdata_i,       // register read data for reg_addr_o
  output logic            full_shutdown_n_o, // full shutdown control, active low
  output logic            audio_path_off_o,  // audio path shutdown, active high
  output logic            codec_run_o,       // codec enabled
  output logic            dsp_run_o          // signal processor enabled
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [5:0] pin_s;
  logic [5:0] pin_p;

  pin_sync #(.W(6), .RST(PIN_RST)) u_sync (
    .clk_i  (core_clk_i),
    .nrst_i (nrst_i),
    .en_i   (clk_en_i),
    .pin_i  ({port_sel_i, addr_sel_i, cs_n_i, sda_mosi_i, scl_sclk_i}),
    .lvl_o  (pin_s),
    .prv_o  (pin_p)
  );

  logic       spi_mode;
  logic [1:0] asel;
  logic       cs_n_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       ev_start;
  logic       ev_stop;

  assign spi_mode = pin_s[5];
  assign asel     = pin_s[4:3];
  assign cs_n_s   = pin_s[2];
  assign sda_s    = pin_s[1];
  assign scl_rise = pin_s[0] & ~pin_p[0];
  assign scl_fall = ~pin_s[0] & pin_p[0];
  assign ev_start = pin_s[0] & pin_p[0] & pin_p[1] & ~pin_s[1];
  assign ev_stop  = pin_s[0] & pin_p[0] & ~pin_p[1] & pin_s[1];

  function automatic logic [6:0] slave_addr(input logic [1:0] sel);
    logic [6:0] a;
    a = SLV_ADDR_GND;
    if (sel == ADDR_SEL_DVDD) begin
      a = SLV_ADDR_DVDD;
    end else if (sel == ADDR_SEL_SCL) begin
      a = SLV_ADDR_SCL;
    end
    return a;
  endfunction

  function automatic logic [7:0] sat_inc(input logic [7:0] p);
    return (p == PTR_MAX) ? PTR_MAX : p + 8'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // serial engines and control register

  i2c_state_e st_q, st_d;
  logic [3:0] bits_q, bits_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] ptr_q, ptr_d;
  logic       rw_q, rw_d;
  logic       preset_q, preset_d;
  logic       spulse_q, spulse_d;
  logic       mack_q, mack_d;
  logic       sda_oe_q, sda_oe_d;
  logic [22:0] ssh_q, ssh_d;
  logic [4:0] scnt_q, scnt_d;
  logic [9:0] saddr_q, saddr_d;
  logic       swr_q, swr_d;
  logic       srd_q, srd_d;
  logic [2:0] stxc_q, stxc_d;
  logic [7:0] stx_q, stx_d;
  logic       miso_q, miso_d;
  logic       miso_oe_q, miso_oe_d;
  logic [9:0] raddr_q, raddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic       we_q, we_d;
  logic       re_q, re_d;
  logic       full_shutdown_n_n_q, full_shutdown_n_n_d;
  logic       aoff_q, aoff_d;
  logic       codec_q, codec_d;
  logic       dsp_q, dsp_d;
  logic       i2c_match;

  assign i2c_match = (sh_q[7:1] == slave_addr(asel));

  always_comb begin
    logic [23:0] snx;
    logic [4:0]  cnx;
    snx = {ssh_q, sda_s};
    cnx = scnt_q + 5'h01;
    st_d = st_q;   bits_d = bits_q; sh_d = sh_q;   tx_d = tx_q;
    ptr_d = ptr_q; rw_d = rw_q;     preset_d = preset_q;
    spulse_d = spulse_q; mack_d = mack_q; sda_oe_d = sda_oe_q;
    ssh_d = ssh_q; scnt_d = scnt_q; saddr_d = saddr_q; swr_d = swr_q;
    srd_d = srd_q; stxc_d = stxc_q; stx_d = stx_q; miso_d = miso_q;
    we_d = 1'b0;   re_d = 1'b0;     wdata_d = wdata_q;
    if (spi_mode) begin
      st_d = I2C_IDLE;
      sda_oe_d = 1'b0;
      preset_d = 1'b0;
      if (cs_n_s) begin
        scnt_d = 5'h00;
        srd_d  = 1'b0;
        stxc_d = 3'h0;
        ssh_d  = 23'h00_0000;
      end else if (scl_rise) begin
        ssh_d  = snx[22:0];
        scnt_d = cnx;
        if (cnx == SPI_ADDR_END) begin
          saddr_d = snx[9:0];
          swr_d   = snx[SPI_FLAG_AT_ADDR];
        end
        if (cnx == SPI_HDR_END && !snx[SPI_FLAG_AT_HDR]) begin
          srd_d = 1'b1;
        end
        if (cnx == SPI_WORD_END) begin
          if (swr_q) begin
            we_d    = 1'b1;
            wdata_d = snx[7:0];
            scnt_d  = 5'h00;
          end else begin
            scnt_d  = SPI_HDR_END;
            saddr_d = {saddr_q[9:8], sat_inc(saddr_q[7:0])};
          end
        end
      end else if (scl_fall && srd_q) begin
        if (stxc_q == 3'h0) begin
          miso_d = reg_rdata_i[7];
          stx_d  = {reg_rdata_i[6:0], 1'b0};
          re_d   = 1'b1;
        end else begin
          miso_d = stx_q[7];
          stx_d  = {stx_q[6:0], 1'b0};
        end
        stxc_d = stxc_q + 3'h1;
      end
    end else begin
      scnt_d = 5'h00;
      srd_d  = 1'b0;
      stxc_d = 3'h0;
      if (scl_fall) begin
        spulse_d = 1'b0;
      end
      if (ev_start) begin
        st_d = I2C_ADDR;
        bits_d = 4'h0;
        sda_oe_d = 1'b0;
        spulse_d = 1'b1;
      end else if (ev_stop && !spulse_q) begin
        st_d = I2C_IDLE;
        sda_oe_d = 1'b0;
        preset_d = 1'b0;
      end else if (scl_rise) begin
        if (st_q inside {I2C_ADDR, I2C_PTR, I2C_WDATA}) begin
          sh_d = {sh_q[6:0], sda_s};
          bits_d = bits_q + 4'h1;
        end
        if (st_q == I2C_RDATA_ACK) begin
          mack_d = ~sda_s;
        end
      end else if (scl_fall) begin
        unique case (st_q)
          I2C_ADDR: if (bits_q == I2C_BYTE_BITS) begin
            if (i2c_match) begin
              sda_oe_d = 1'b1;
              rw_d = sh_q[0];
              st_d = I2C_ADDR_ACK;
              if (sh_q[0] && !preset_q) begin
                ptr_d = PTR_RST;
              end
            end else begin
              st_d = I2C_IGNORE;
            end
          end
          I2C_ADDR_ACK: begin
            bits_d = 4'h0;
            sda_oe_d = 1'b0;
            st_d = I2C_PTR;
            if (rw_q) begin
              tx_d = {reg_rdata_i[6:0], 1'b0};
              sda_oe_d = ~reg_rdata_i[7];
              bits_d = 4'h1;
              re_d = 1'b1;
              st_d = I2C_RDATA;
            end
          end
          I2C_PTR: if (bits_q == I2C_BYTE_BITS) begin
            ptr_d = sh_q;
            preset_d = 1'b1;
            sda_oe_d = 1'b1;
            st_d = I2C_PTR_ACK;
          end
          I2C_PTR_ACK, I2C_WDATA_ACK: begin
            sda_oe_d = 1'b0;
            bits_d = 4'h0;
            st_d = I2C_WDATA;
            if (st_q == I2C_WDATA_ACK && ptr_q != PTR_NO_INC) begin
              ptr_d = sat_inc(ptr_q);
            end
          end
          I2C_WDATA: if (bits_q == I2C_BYTE_BITS) begin
            we_d = 1'b1;
            wdata_d = sh_q;
            sda_oe_d = 1'b1;
            st_d = I2C_WDATA_ACK;
          end
          I2C_RDATA: begin
            if (bits_q == I2C_BYTE_BITS) begin
              sda_oe_d = 1'b0;
              ptr_d = sat_inc(ptr_q);
              st_d = I2C_RDATA_ACK;
            end else begin
              sda_oe_d = ~tx_q[7];
              tx_d = {tx_q[6:0], 1'b0};
              bits_d = bits_q + 4'h1;
            end
          end
          I2C_RDATA_ACK: begin
            if (mack_q) begin
              tx_d = {reg_rdata_i[6:0], 1'b0};
              sda_oe_d = ~reg_rdata_i[7];
              bits_d = 4'h1;
              re_d = 1'b1;
              st_d = I2C_RDATA;
            end else begin
              sda_oe_d = 1'b0;
              st_d = I2C_IGNORE;
            end
          end
          I2C_IDLE, I2C_IGNORE: begin
          end
        endcase
      end
    end
    miso_oe_d = srd_d & ~cs_n_s & spi_mode;
    raddr_d = spi_mode ? saddr_d : {2'b00, ptr_d};
    full_shutdown_n_n_d = full_shutdown_n_n_q;
    aoff_d = aoff_q;
    if (we_d && raddr_q == CTRL_REG_ADDR) begin
      full_shutdown_n_n_d = wdata_d[CTRL_FULL_SHUTDOWN_N_N_BIT];
      aoff_d = wdata_d[CTRL_AUDIO_OFF_BIT];
    end
    dsp_d = full_shutdown_n_n_q;
    codec_d = full_shutdown_n_n_q & ~aoff_q;
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      st_q <= I2C_IDLE;  bits_q <= 4'h0;     sh_q <= 8'h00;    tx_q <= 8'h00;
      ptr_q <= PTR_RST;  rw_q <= 1'b0;       preset_q <= 1'b0; spulse_q <= 1'b0;
      mack_q <= 1'b0;    sda_oe_q <= 1'b0;   ssh_q <= 23'h00_0000;
      scnt_q <= 5'h00;   saddr_q <= 10'h000; swr_q <= 1'b0;    srd_q <= 1'b0;
      stxc_q <= 3'h0;    stx_q <= 8'h00;     miso_q <= 1'b0;   miso_oe_q <= 1'b0;
      raddr_q <= 10'h000; wdata_q <= 8'h00;  we_q <= 1'b0;     re_q <= 1'b0;
      full_shutdown_n_n_q <= FULL_SHUTDOWN_N_N_RST; aoff_q <= AUDIO_OFF_RST;
      codec_q <= 1'b0;   dsp_q <= 1'b0;
    end else if (clk_en_i) begin
      st_q <= st_d;      bits_q <= bits_d;   sh_q <= sh_d;     tx_q <= tx_d;
      ptr_q <= ptr_d;    rw_q <= rw_d;       preset_q <= preset_d; spulse_q <= spulse_d;
      mack_q <= mack_d;  sda_oe_q <= sda_oe_d; ssh_q <= ssh_d;
      scnt_q <= scnt_d;  saddr_q <= saddr_d; swr_q <= swr_d;   srd_q <= srd_d;
      stxc_q <= stxc_d;  stx_q <= stx_d;     miso_q <= miso_d; miso_oe_q <= miso_oe_d;
      raddr_q <= raddr_d; wdata_q <= wdata_d; we_q <= we_d;    re_q <= re_d;
      full_shutdown_n_n_q <= full_shutdown_n_n_d; aoff_q <= aoff_d;
      codec_q <= codec_d; dsp_q <= dsp_d;
    end
  end

  assign sda_o             = 1'b0;
  assign sda_oe_o          = sda_oe_q;
  assign miso_o            = miso_q;
  assign miso_oe_o         = miso_oe_q;
  assign reg_addr_o        = raddr_q;
  assign reg_wdata_o       = wdata_q;
  assign reg_we_o          = we_q;
  assign reg_re_o          = re_q;
  assign full_shutdown_n_o = full_shutdown_n_n_q;
  assign audio_path_off_o  = aoff_q;
  assign codec_run_o       = codec_q;
  assign dsp_run_o         = dsp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  logic byte_end;
  assign byte_end = clk_en_i && !spi_mode && scl_fall && !ev_start && !ev_stop && bits_q == I2C_BYTE_BITS;

  a_ack_on_match: assert property (byte_end && st_q == I2C_ADDR && i2c_match |=> sda_oe_q)
    else $error("matching address not acknowledged");
  a_nack_on_miss: assert property (byte_end && st_q == I2C_ADDR && !i2c_match
    |=> st_q == I2C_IGNORE && !sda_oe_q)
    else $error("foreign address acknowledged");
  a_ptr_load: assert property (byte_end && st_q == I2C_PTR |=> ptr_q == $past(sh_q))
    else $error("pointer byte not loaded");
  a_ptr_zero_hold: assert property (clk_en_i && scl_fall && !ev_start && !ev_stop && !spi_mode
    && st_q == I2C_WDATA_ACK && ptr_q == PTR_NO_INC |=> ptr_q == PTR_NO_INC)
    else $error("pointer advanced from register zero");
  a_ptr_no_wrap: assert property (ptr_q == PTR_MAX && st_q inside {I2C_WDATA_ACK, I2C_RDATA}
    |=> ptr_q == PTR_MAX)
    else $error("pointer wrapped into next page");
  a_read_ptr_reset: assert property (byte_end && st_q == I2C_ADDR && i2c_match && sh_q[0]
    && !preset_q |=> ptr_q == PTR_RST ##1 st_q == I2C_ADDR_ACK)
    else $error("read start did not reset pointer");
  a_spi_cs_reset: assert property (clk_en_i && spi_mode && cs_n_s |=> !miso_oe_q && scnt_q == 5'h00)
    else $error("spi logic active while deselected");
  a_spi_full_word: assert property ($rose(we_q) && spi_mode |-> $past(scnt_q) == SPI_WORD_END - 5'h01)
    else $error("spi write from a partial word");
  a_miso_after_addr: assert property ($rose(miso_oe_q) |-> scnt_q == SPI_HDR_END && !swr_q)
    else $error("miso driven before address decoded");
  a_codec_gated: assert property (!full_shutdown_n_n_q |=> !codec_q && !dsp_q)
    else $error("function running in full shutdown");

  c_i2c_write: cover property (st_q == I2C_WDATA_ACK ##1 st_q == I2C_WDATA);
  c_i2c_read: cover property (st_q == I2C_RDATA_ACK ##1 st_q == I2C_RDATA);
  c_spi_write: cover property (we_q && spi_mode);
  c_spi_read: cover property (re_q && spi_mode);

endmodule

/* File: rtl/host_port_pkg.sv */
package host_port_pkg;

  // 7-bit slave addresses per address-select pin level
  localparam logic [6:0] SLV_ADDR_GND  = 7'h10;
  localparam logic [6:0] SLV_ADDR_DVDD = 7'h11;
  localparam logic [6:0] SLV_ADDR_SCL  = 7'h13;
  localparam logic [1:0] ADDR_SEL_GND  = 2'h0;
  localparam logic [1:0] ADDR_SEL_DVDD = 2'h1;
  localparam logic [1:0] ADDR_SEL_SCL  = 2'h2;

  // register pointer limits within one page
  localparam logic [7:0] PTR_NO_INC = 8'h00;
  localparam logic [7:0] PTR_MAX    = 8'hFF;
  localparam logic [7:0] PTR_RST    = 8'h00;

  // i2c bit counts
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

  // spi word layout: flag, 10 address bits, 5 reserved, 8 data
  localparam logic [4:0] SPI_ADDR_END = 5'h0B;
  localparam logic [4:0] SPI_HDR_END  = 5'h10;
  localparam logic [4:0] SPI_WORD_END = 5'h18;
  localparam int         SPI_FLAG_AT_ADDR = 10;
  localparam int         SPI_FLAG_AT_HDR  = 15;

  // shutdown control register inside the register space
  localparam logic [9:0] CTRL_REG_ADDR      = 10'h00FF;
  localparam int         CTRL_FULL_SHUTDOWN_N_N_BIT    = 0;
  localparam int         CTRL_AUDIO_OFF_BIT = 1;
  localparam logic       FULL_SHUTDOWN_N_N_RST         = 1'b0;
  localparam logic       AUDIO_OFF_RST      = 1'b1;

  // pin synchroniser idle levels {port_sel, addr_sel[1:0], cs_n, sda, scl}
  localparam logic [5:0] PIN_RST = 6'h07;

  typedef enum logic [9:0] {
    I2C_IDLE      = 10'h001,
    I2C_ADDR      = 10'h002,
    I2C_ADDR_ACK  = 10'h004,
    I2C_PTR       = 10'h008,
    I2C_PTR_ACK   = 10'h010,
    I2C_WDATA     = 10'h020,
    I2C_WDATA_ACK = 10'h040,
    I2C_RDATA     = 10'h080,
    I2C_RDATA_ACK = 10'h100,
    I2C_IGNORE    = 10'h200
  } i2c_state_e;

endpackage

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
  import host_port_pkg::*;
#(
  parameter int         W   = 6,
  parameter logic [5:0] RST = PIN_RST
) (
  input  wire logic         clk_i,   // core clock
  input  wire logic         nrst_i,  // sync reset, active low
  input  wire logic         en_i,    // clock enable
  input  wire logic [W-1:0] pin_i,   // asynchronous pins
  output logic      [W-1:0] lvl_o,   // synchronised level
  output logic      [W-1:0] prv_o    // level one cycle earlier
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s1_q <= RST[W-1:0];
      s2_q <= RST[W-1:0];
      s3_q <= RST[W-1:0];
    end else if (en_i) begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign lvl_o = s2_q;
  assign prv_o = s3_q;

endmodule

/* File: tb/host_master.sv */
`timescale 1ns/1ps
module host_master (
  input  wire logic clk_i,      // core clock
  input  wire logic port_sel_i, // 1 selects spi
  input  wire logic sda_oe_i,   // slave pulls sda low
  input  wire logic miso_i,     // spi data from slave
  input  wire logic miso_oe_i,  // miso driven
  output logic      scl_sclk_o, // scl or sclk
  output logic      sda_mosi_o, // resolved sda or mosi
  output logic      cs_n_o      // spi select, active low
);
  localparam int H = 8;
  localparam int S = 4;
  logic sda_m;
  logic mosi;
  logic sda_w;
  // sda has a pull-up, so a released line reads high
  assign sda_w      = sda_m & ~sda_oe_i;
  assign sda_mosi_o = port_sel_i ? mosi : sda_w;
  initial begin
    sda_m = 1'b1;
    mosi = 1'b0;
    scl_sclk_o = 1'b1;
    cs_n_o = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic i2c_start;
    w(2);
    sda_m <= 1'b1;
    w(H);
    scl_sclk_o <= 1'b1;
    w(H);
    sda_m <= 1'b0;
    w(H);
    scl_sclk_o <= 1'b0;
  endtask
  task automatic i2c_stop;
    w(2);
    sda_m <= 1'b0;
    w(H);
    scl_sclk_o <= 1'b1;
    w(H);
    sda_m <= 1'b1;
    w(H);
  endtask
  // sample at the rising edge of scl
  task automatic i2c_bit(input logic b, output logic r);
    w(2);
    sda_m <= b;
    w(H - 1);
    @(negedge clk_i);
    r = sda_w;
    @(posedge clk_i);
    scl_sclk_o <= 1'b1;
    w(H);
    scl_sclk_o <= 1'b0;
  endtask
  task automatic i2c_xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) i2c_bit(tx[i], rx[i]);
  endtask
  // words go msb first, sclk idles low, 200 ns period
  task automatic spi(input logic [191:0] tx, input int n, input logic sel,
                     output logic [7:0] rx, output logic oe_e);
    oe_e = 1'b0;
    scl_sclk_o <= 1'b0;
    w(S);
    cs_n_o <= ~sel;
    w(S);
    for (int i = 0; i < n; i++) begin
      mosi <= tx[191-i];
      w(S);
      scl_sclk_o <= 1'b1;
      w(S - 1);
      @(negedge clk_i);
      // a released miso reads as the inverse of its last value
      rx = {rx[6:0], miso_oe_i ? miso_i : ~miso_i};
      if (i < 10) oe_e = oe_e | miso_oe_i;
      @(posedge clk_i);
      scl_sclk_o <= 1'b0;
    end
    w(S);
    cs_n_o <= 1'b1;
    mosi <= ~mosi;
    w(2 * S);
  endtask
endmodule

/* File: tb/host_ctrl_port_test.sv */
`timescale 1ns/1ps
module host_ctrl_port_test;
  import host_port_pkg::*;
  logic        clk;
  logic        nrst;
  logic        port_sel;
  logic [1:0]  addr_sel;
  logic        scl;
  logic        sdam;
  logic        cs_n;
  logic        sda_oe;
  logic        miso;
  logic        miso_oe;
  logic [9:0]  raddr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        we;
  logic        re;
  logic        full_shutdown_n_n;
  logic        aoff;
  logic        codec;
  logic        dsp;
  logic [7:0]  mem [256];
  logic [17:0] wlog [$];
  logic [8:0]  rx9;
  logic [7:0]  rx8;
  logic        oe_e;
  logic [7:0]  wa [3];
  int          miscompares;
  int          checks;
  int          rd_cnt = 0;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // register space stand-in, read combinationally
  assign rdata = mem[raddr[7:0]];
  always @(posedge clk) begin
    if (we === 1'b1) begin
      mem[raddr[7:0]] <= wdata;
      wlog.push_back({raddr, wdata});
    end
    if (re === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
    end
  end
  host_ctrl_port u_host_ctrl_port (.core_clk_i(clk), .nrst_i(nrst), .clk_en_i(1'b1), .port_sel_i(port_sel),
    .addr_sel_i(addr_sel), .scl_sclk_i(scl), .sda_mosi_i(sdam), .cs_n_i(cs_n), .sda_o(), .sda_oe_o(sda_oe),
    .miso_o(miso), .miso_oe_o(miso_oe), .reg_addr_o(raddr), .reg_wdata_o(wdata), .reg_we_o(we), .reg_re_o(re),
    .reg_rdata_i(rdata), .full_shutdown_n_o(full_shutdown_n_n), .audio_path_off_o(aoff), .codec_run_o(codec),
    .dsp_run_o(dsp));
  host_master u_host_master (.clk_i(clk), .port_sel_i(port_sel), .sda_oe_i(sda_oe), .miso_i(miso),
    .miso_oe_i(miso_oe), .scl_sclk_o(scl), .sda_mosi_o(sdam), .cs_n_o(cs_n));
  function automatic logic [7:0] pat(input int i);
    return 8'(i) ^ 8'h5A;
  endfunction
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_w(input logic [9:0] a, input logic [7:0] d);
    chk("write", {a, d}, (wlog.size() > 0) ? wlog.pop_front() : 18'h3_ffff);
  endtask
  task automatic i2c_wr(input logic [7:0] adr, input logic [7:0] ptr, input logic [23:0] d, input int n,
                        input logic ack_e);
    u_host_master.i2c_start();
    u_host_master.i2c_xfer({adr, 1'b1}, rx9);
    chk("addr ack", {17'h0_0000, ~ack_e}, 18'(rx9[0]));
    if (ack_e) begin
      u_host_master.i2c_xfer({ptr, 1'b1}, rx9);
      chk("ptr ack", 18'h0, 18'(rx9[0]));
      for (int i = 0; i < n; i++) begin
        u_host_master.i2c_xfer({d[23-8*i -: 8], 1'b1}, rx9);
        chk("data ack", 18'h0, 18'(rx9[0]));
      end
    end
    u_host_master.i2c_stop();
  endtask
  task automatic i2c_rd(input logic [7:0] ptr, input logic pre, input logic [23:0] e, input int n);
    int r0;
    r0 = rd_cnt;
    u_host_master.i2c_start();
    if (pre) begin
      u_host_master.i2c_xfer({8'h20, 1'b1}, rx9);
      chk("preset addr ack", 18'h0, 18'(rx9[0]));
      u_host_master.i2c_xfer({ptr, 1'b1}, rx9);
      chk("preset ptr ack", 18'h0, 18'(rx9[0]));
      u_host_master.i2c_start();
    end
    u_host_master.i2c_xfer({8'h21, 1'b1}, rx9);
    chk("read ack", 18'h0, 18'(rx9[0]));
    for (int i = 0; i < n; i++) begin
      u_host_master.i2c_xfer({8'hFF, 1'(i == n - 1)}, rx9);
      chk("read", 18'(e[23-8*i -: 8]), 18'(rx9[8:1]));
    end
    u_host_master.i2c_stop();
    chk("read strobes", 18'(n), 18'(rd_cnt - r0));
  endtask
  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  initial begin
    nrst = 1'b0;
    port_sel = 1'b0;
    addr_sel = 2'h0;
    miscompares = 0;
    checks = 0;
    wa = '{8'h20, 8'h22, 8'h26};
    for (int i = 0; i < 256; i++) mem[i] = pat(i);
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk("reset", 18'h10, 18'({full_shutdown_n_n, aoff, codec, dsp, sda_oe, miso_oe}));
    for (int k = 0; k < 3; k++) begin
      addr_sel <= 2'(k);
      repeat (4) @(posedge clk);
      i2c_wr(wa[k], 8'(8'h10 + k), {8'(8'hC0 + k), 16'h0}, 1, 1'b1);
      chk_w(10'(8'h10 + k), 8'(8'hC0 + k));
      i2c_wr(wa[(k + 1) % 3], 8'h40, 24'h0, 1, 1'b0);
      chk("no write", 18'h0, 18'(wlog.size()));
    end
    addr_sel <= 2'h0;
    // configure with full shutdown held, then enable
    i2c_wr(8'h20, 8'hFE, {8'h11, 8'h02, 8'h01}, 3, 1'b1);
    chk_w(10'h0FE, 8'h11);
    chk_w(10'h0FF, 8'h02);
    chk_w(10'h0FF, 8'h01);
    chk("ctl on", 18'hB, 18'({full_shutdown_n_n, aoff, codec, dsp}));
    i2c_wr(8'h20, 8'h00, {8'h33, 8'h44, 8'h00}, 2, 1'b1);
    chk_w(10'h000, 8'h33);
    chk_w(10'h000, 8'h44);
    i2c_rd(8'h00, 1'b0, {8'h44, pat(1), 8'h00}, 2);
    i2c_rd(8'h30, 1'b1, {pat(48), pat(49), pat(50)}, 3);
    port_sel <= 1'b1;
    repeat (6) @(posedge clk);
    u_host_master.spi({1'b1, 10'h123, 5'h0, 8'h5C, 168'h0}, 24, 1'b1, rx8, oe_e);
    chk_w(10'h123, 8'h5C);
    chk("miso early", 18'h0, 18'(oe_e));
    u_host_master.spi({1'b1, 10'h0FF, 5'h0, 8'h03, 1'b1, 10'h104, 5'h0, 8'hA1, 144'h0},
                      48, 1'b1, rx8, oe_e);
    chk_w(10'h0FF, 8'h03);
    chk_w(10'h104, 8'hA1);
    chk("ctl codec off", 18'hD, 18'({full_shutdown_n_n, aoff, codec, dsp}));
    u_host_master.spi({1'b1, 10'h050, 5'h0, 8'hEE, 168'h0}, 20, 1'b1, rx8, oe_e);
    u_host_master.spi({1'b1, 10'h050, 5'h0, 8'hEE, 168'h0}, 24, 1'b0, rx8, oe_e);
    chk("no write", 18'h0, 18'(wlog.size()));
    u_host_master.spi({1'b0, 10'h031, 5'h0, 8'h00, 168'h0}, 24, 1'b1, rx8, oe_e);
    chk("spi read", 18'(pat(49)), 18'(rx8));
    chk("miso early", 18'h0, 18'(oe_e));
    chk("miso idle", 18'h0, 18'(miso_oe));
    u_host_master.spi({1'b1, 10'h0FF, 5'h0, 8'h00, 168'h0}, 24, 1'b1, rx8, oe_e);
    chk_w(10'h0FF, 8'h00);
    chk("ctl all off", 18'h0, 18'({full_shutdown_n_n, aoff, codec, dsp}));
    stop_test();
  end
endmodule
